// file: common/lpmr_defs.svh
// Offsets, field positions, codes and reset values of the mode register bank
`ifndef LPMR_DEFS_SVH
`define LPMR_DEFS_SVH
`define LPMR_MA_LATENCY      8'h02
`define LPMR_MA_DRIVE        8'h03
`define LPMR_MA_TEMP         8'h04
`define LPMR_MA_VENDOR       8'h05
`define LPMR_MA_REV1         8'h06
`define LPMR_MA_REV2         8'h07
`define LPMR_MA_GEOM         8'h08
`define LPMR_MA_TEST         8'h09
`define LPMR_MA_CAL          8'h0a
`define LPMR_TUF_BIT         7
`define LPMR_RATE_HOT_BIT    2
`define LPMR_LAT_RESET       4'h1
`define LPMR_DS_RESET        4'h2
`define LPMR_RATE_RESET      3'h3
`define LPMR_REV2_VALUE      8'h3c // Arbitrary value
`define LPMR_CAL_INIT        8'hff
`define LPMR_CAL_LONG        8'hab
`define LPMR_CAL_SHORT       8'h56
`define LPMR_CAL_ZQRST       8'hc3
`define LPMR_TYPE_NVM        2'h2
`define LPMR_DENS_512MB      4'h3
`define LPMR_DENS_MAX        4'h9
`define LPMR_WIDTH_X32       2'h0
`define LPMR_HOT_LIMIT_C     8'h55
`endif

// file: common/lpmr_pkg.sv
// Types of the mode register bank
package lpmr_pkg;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpmr_cmd_t;
  typedef struct packed {
    logic [3:0] read_latency;
    logic [2:0] write_latency;
  } lpmr_lat_t;
  typedef enum logic [3:0] {
    LPMR_CAL_NONE  = 4'b0001,
    LPMR_CAL_INITC = 4'b0010,
    LPMR_CAL_LONGC = 4'b0100,
    LPMR_CAL_SHRTC = 4'b1000
  } lpmr_cal_t;
endpackage : lpmr_pkg

// file: hw/lpmr_decode.sv
// Decoder of the latency code into read and write latency
`timescale 1ns/1ns
`include "lpmr_defs.svh"
module lpmr_decode (
  input  wire logic [3:0]         code,
  output lpmr_pkg::lpmr_lat_t     lat,
  output logic                    legal
);
  always_comb
  begin
    legal = 1'b1;
    lat   = '{read_latency: 4'h3, write_latency: 3'h1};
    unique case (code)
      4'h1: lat = '{read_latency: 4'h3, write_latency: 3'h1};
      4'h2: lat = '{read_latency: 4'h4, write_latency: 3'h2};
      4'h3: lat = '{read_latency: 4'h5, write_latency: 3'h2};
      4'h4: lat = '{read_latency: 4'h6, write_latency: 3'h3};
      4'h5: lat = '{read_latency: 4'h7, write_latency: 3'h4};
      4'h6: lat = '{read_latency: 4'h8, write_latency: 3'h4};
      default: legal = 1'b0;
    endcase
  end
endmodule : lpmr_decode

// file: hw/lpmr_bank.sv
// Mode register bank with command port, sensor input and decoded configuration
`timescale 1ns/1ns
`include "lpmr_defs.svh"
module lpmr_bank #(
  parameter logic [7:0] VENDOR_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REV_ID    = 8'h11, // Arbitrary value
  parameter logic [1:0] MEM_TYPE  = 2'h0,
  parameter logic [3:0] DENSITY   = `LPMR_DENS_512MB,
  parameter logic [1:0] IO_WIDTH  = `LPMR_WIDTH_X32
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  lpmr_pkg::lpmr_cmd_t      cmd,
  input  wire logic [2:0]          sensed_rate,
  input  wire logic [7:0]          sensed_temp_c,
  output logic [7:0]               rdata_ff,
  output logic                     rvalid_ff,
  output logic [3:0]               read_latency_ff,
  output logic [2:0]               write_latency_ff,
  output logic [3:0]               drive_strength_ff,
  output lpmr_pkg::lpmr_cal_t      cal_cmd_ff,
  output logic                     derate_ff
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]          lat_code_ff;
  logic [2:0]          rate_ff;
  logic                tuf_ff;
  lpmr_pkg::lpmr_lat_t lat_dec;
  lpmr_pkg::lpmr_lat_t new_lat;
  logic                new_lat_ok;
  logic [2:0]          nxt_rate;
  logic                nxt_tuf;
  logic [7:0]          nxt_rdata;
  lpmr_pkg::lpmr_cal_t nxt_cal;
  wire is_wr    = cmd.valid & cmd.write;
  wire is_rd    = cmd.valid & ~cmd.write;
  wire hit_lat  = cmd.addr == `LPMR_MA_LATENCY;
  wire hit_ds   = cmd.addr == `LPMR_MA_DRIVE;
  wire hit_temp = cmd.addr == `LPMR_MA_TEMP;
  wire hit_cal  = cmd.addr == `LPMR_MA_CAL;
  wire hit_vend = cmd.addr == `LPMR_MA_VENDOR;
  wire hit_rev1 = cmd.addr == `LPMR_MA_REV1;
  wire hit_rev2 = cmd.addr == `LPMR_MA_REV2;
  wire hit_geom = cmd.addr == `LPMR_MA_GEOM;
  wire hit_test = cmd.addr == `LPMR_MA_TEST;
  wire ds_ok    = (cmd.wdata[3:0] >= 4'h1) && (cmd.wdata[3:0] <= 4'h7)
                  && (cmd.wdata[3:0] != 4'h5);
  // hot code only when sensor above 85 C
  wire hot      = sensed_temp_c > `LPMR_HOT_LIMIT_C;
  // calibration codes that carry an action
  wire cal_known = (cmd.wdata == `LPMR_CAL_INIT) || (cmd.wdata == `LPMR_CAL_LONG)
                   || (cmd.wdata == `LPMR_CAL_SHORT) || (cmd.wdata == `LPMR_CAL_ZQRST);
  ////////////////////////////////////////////////////////////////////////////
  lpmr_decode u_cur (
    .code  (lat_code_ff),
    .lat   (lat_dec),
    .legal ()
  );
  lpmr_decode u_new (
    .code  (cmd.wdata[3:0]),
    .lat   (new_lat),
    .legal (new_lat_ok)
  );
  ////////////////////////////////////////////////////////////////////////////
  // refresh-rate code tracking, reserved 100b held off
  always_comb
  begin
    nxt_rate = rate_ff;
    if (sensed_rate != 3'h4)
    begin
      nxt_rate = sensed_rate;
    end
    // A held hot code must also fall back once the die cools
    if (!hot && nxt_rate[2] && nxt_rate != 3'h7)
    begin
      nxt_rate = 3'h3;
    end
  end
  // set on change wins over read clear
  assign nxt_tuf = (nxt_rate != rate_ff) ? 1'b1 :
                   (is_rd && hit_temp) ? 1'b0 : tuf_ff;
  always_comb
  begin
    nxt_rdata = 8'h00;
    unique case (cmd.addr)
      `LPMR_MA_TEMP:   nxt_rdata = {tuf_ff, 4'h0, rate_ff};
      `LPMR_MA_VENDOR: nxt_rdata = VENDOR_ID;
      `LPMR_MA_REV1:   nxt_rdata = REV_ID;
      `LPMR_MA_REV2:   nxt_rdata = `LPMR_REV2_VALUE;
      `LPMR_MA_GEOM:   nxt_rdata = {IO_WIDTH, DENSITY, MEM_TYPE};
      default:         nxt_rdata = 8'h00;
    endcase
  end
  always_comb
  begin
    nxt_cal = lpmr_pkg::LPMR_CAL_NONE;
    if (is_wr && hit_cal)
    begin
      unique case (cmd.wdata)
        `LPMR_CAL_INIT:  nxt_cal = lpmr_pkg::LPMR_CAL_INITC;
        `LPMR_CAL_LONG:  nxt_cal = lpmr_pkg::LPMR_CAL_LONGC;
        `LPMR_CAL_SHORT: nxt_cal = lpmr_pkg::LPMR_CAL_SHRTC;
        default:         nxt_cal = lpmr_pkg::LPMR_CAL_NONE;
      endcase
    end
  end
  wire zq_reset = is_wr && hit_cal && cmd.wdata == `LPMR_CAL_ZQRST;
  ////////////////////////////////////////////////////////////////////////////
  // flag and config defaults after reset
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tuf_ff  <= 1'b0;
      rate_ff <= `LPMR_RATE_RESET;
    end
    else
    begin
      tuf_ff  <= nxt_tuf;
      rate_ff <= nxt_rate;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      lat_code_ff <= `LPMR_LAT_RESET;
    end
    else if (is_wr && hit_lat && new_lat_ok)
    begin
      lat_code_ff <= cmd.wdata[3:0];
    end
  end
  // drive register write and impedance reset
  // Impedance reset shares the reset path so the default lands in one cycle
  always_ff @(posedge core_clk)
  begin
    if (!resetn || zq_reset)
    begin
      drive_strength_ff <= `LPMR_DS_RESET;
    end
    else if (is_wr && hit_ds && ds_ok)
    begin
      drive_strength_ff <= cmd.wdata[3:0];
    end
  end
  // read answer one cycle after the command
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      // Zero between reads keeps stale register data off the bus
      rdata_ff  <= is_rd ? nxt_rdata : 8'h00;
      rvalid_ff <= is_rd;
    end
  end
  // decoded latency, one cycle behind the code
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      read_latency_ff  <= 4'h3;
      write_latency_ff <= 3'h1;
    end
    else
    begin
      read_latency_ff  <= lat_dec.read_latency;
      write_latency_ff <= lat_dec.write_latency;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cal_cmd_ff <= lpmr_pkg::LPMR_CAL_NONE;
    end
    else
    begin
      cal_cmd_ff <= nxt_cal;
    end
  end
  // derate level follows the 110b code
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      derate_ff <= 1'b0;
    end
    else
    begin
      derate_ff <= rate_ff == 3'h6;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence temp_read_s;
    is_rd && hit_temp && nxt_rate == rate_ff;
  endsequence
  sequence lat_good_s;
    is_wr && hit_lat && new_lat_ok;
  endsequence
  sequence lat_bad_s;
    is_wr && hit_lat && !new_lat_ok;
  endsequence
  sequence ds_good_s;
    is_wr && hit_ds && ds_ok;
  endsequence
  sequence cal_bad_s;
    is_wr && hit_cal && !cal_known;
  endsequence
  sequence cal_long_s;
    is_wr && hit_cal && cmd.wdata == `LPMR_CAL_LONG;
  endsequence
  sequence rate_hold_s;
    sensed_rate == 3'h4 && (hot || !rate_ff[2] || rate_ff == 3'h7);
  endsequence
  tuf_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    temp_read_s |=> !tuf_ff)
    else $error("flag not cleared by read");
  tuf_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rate_ff != $past(rate_ff)) |-> tuf_ff)
    else $error("flag not set on change");
  tuf_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(tuf_ff) |-> rate_ff != $past(rate_ff))
    else $error("flag rose without change");
  hot_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rate_ff[2] && rate_ff != 3'h7) |-> $past(hot))
    else $error("hot code while cool");
  rate_rsvd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    rate_ff != 3'h4)
    else $error("reserved rate code");
  temp_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && hit_temp) |=> rvalid_ff && rdata_ff[2:0] == $past(rate_ff))
    else $error("bad temperature read");
  geom_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && cmd.addr == `LPMR_MA_GEOM) |=> rdata_ff[5:2] == DENSITY)
    else $error("bad geometry read");
  wo_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && (hit_ds || hit_lat)) |=> rdata_ff == 8'h00)
    else $error("write-only reg readable");
  ds_legal_a: assert property (@(posedge core_clk) disable iff (!resetn)
    drive_strength_ff != 4'h0 && drive_strength_ff != 4'h5 && drive_strength_ff < 4'h8)
    else $error("reserved drive code");
  lat_apply_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_wr && hit_lat && cmd.wdata[3:0] == 4'h6) |=> ##1 read_latency_ff == 4'h8)
    else $error("latency not applied");
  cal_rsvd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cal_bad_s |=> cal_cmd_ff == lpmr_pkg::LPMR_CAL_NONE)
    else $error("reserved cal acted");
  cal_long_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cal_long_s |=> cal_cmd_ff == lpmr_pkg::LPMR_CAL_LONGC)
    else $error("long cal pulse missing");
  cal_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !(is_wr && hit_cal) |=> cal_cmd_ff == lpmr_pkg::LPMR_CAL_NONE)
    else $error("cal pulse without write");
  lat_good_a: assert property (@(posedge core_clk) disable iff (!resetn)
    lat_good_s |=> lat_code_ff == $past(cmd.wdata[3:0]))
    else $error("latency code not stored");
  lat_rsvd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    lat_bad_s |=> lat_code_ff == $past(lat_code_ff))
    else $error("reserved latency stored");
  lat_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (lat_code_ff == 4'h3) |=> read_latency_ff == 4'h5 && write_latency_ff == 3'h2)
    else $error("latency decode wrong");
  ds_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ds_good_s |=> drive_strength_ff == $past(cmd.wdata[3:0]))
    else $error("drive code not stored");
  ds_zq_a: assert property (@(posedge core_clk) disable iff (!resetn)
    zq_reset |=> drive_strength_ff == `LPMR_DS_RESET)
    else $error("impedance reset missed");
  rate_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    rate_hold_s |=> rate_ff == $past(rate_ff))
    else $error("reserved rate not held");
  rate_track_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !sensed_rate[2] |=> rate_ff == $past(sensed_rate))
    else $error("rate code not tracked");
  rate_limit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (sensed_rate == 3'h7) |=> rate_ff == 3'h7)
    else $error("high limit not reported");
  derate_on_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rate_ff == 3'h6) |=> derate_ff)
    else $error("derate missing");
  derate_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (rate_ff != 3'h6) |=> !derate_ff)
    else $error("derate without code");
  rd_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    is_rd |=> rvalid_ff)
    else $error("read not answered");
  rd_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !is_rd |=> !rvalid_ff && rdata_ff == 8'h00)
    else $error("read data without read");
  vendor_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && hit_vend) |=> rdata_ff == VENDOR_ID)
    else $error("bad vendor read");
  rev1_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && hit_rev1) |=> rdata_ff == REV_ID)
    else $error("bad first revision read");
  rev2_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && hit_rev2) |=> rdata_ff == `LPMR_REV2_VALUE)
    else $error("bad second revision read");
  type_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && hit_geom) |=> rdata_ff[1:0] == MEM_TYPE)
    else $error("bad memory type read");
  width_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && hit_geom) |=> rdata_ff[7:6] == IO_WIDTH)
    else $error("bad io width read");
  test_rd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (is_rd && hit_test) |=> rdata_ff == 8'h00)
    else $error("test register readable");
  tuf_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!tuf_ff && nxt_rate == rate_ff) |=> !tuf_ff)
    else $error("flag set without change");
endmodule : lpmr_bank

// file: test/lpmr_host.sv
// Controller model that issues mode register commands
`timescale 1ns/1ns
module lpmr_host (
  input  wire logic           core_clk,
  output lpmr_pkg::lpmr_cmd_t cmd,
  input  wire logic [7:0]     rdata_ff,
  input  wire logic           rvalid_ff,
  input  wire logic           derate_ff
);
  real extra_ns;
  initial cmd = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // derate core timings
  always_comb extra_ns = derate_ff ? 1.875 : 0.0;
  // reserved codes only when asked
  // Released fields show inverted values so stale data cannot pass as good
  task automatic mrw(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 cmd = '{1'b1, 1'b1, a, d};
    @(posedge core_clk);
    #1 cmd = '{1'b0, 1'b0, ~a, ~d};
  endtask : mrw
  task automatic mrr(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 cmd = '{1'b1, 1'b0, a, 8'h00};
    @(posedge core_clk);
    #1 cmd = '{1'b0, 1'b0, ~a, 8'hff};
    d = (rvalid_ff === 1'b1) ? rdata_ff : 8'hxx;
  endtask : mrr
endmodule : lpmr_host

// file: test/tb_top.sv
// Self-checking testbench of the mode register bank
`timescale 1ns/1ns
module tb_top;
  logic                core_clk      = 1'b0;
  logic                resetn        = 1'b0;
  logic [2:0]          sensed_rate   = 3'h3;
  logic [7:0]          sensed_temp_c = 8'h19;
  lpmr_pkg::lpmr_cmd_t cmd;
  lpmr_pkg::lpmr_cal_t cal;
  logic [7:0]          rdata_ff;
  logic                rvalid_ff;
  logic                derate_ff;
  logic [3:0]          rl;
  logic [2:0]          wl;
  logic [3:0]          ds;
  int                  err_total     = 0;
  int                  num_checks    = 0;
  int                  cycles        = 0;
  lpmr_bank #(.VENDOR_ID(8'h5a), .REV_ID(8'h11), .MEM_TYPE(2'h2)) DUT (
    .core_clk(core_clk), .resetn(resetn), .cmd(cmd),
    .sensed_rate(sensed_rate), .sensed_temp_c(sensed_temp_c), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .read_latency_ff(rl), .write_latency_ff(wl),
    .drive_strength_ff(ds), .cal_cmd_ff(cal), .derate_ff(derate_ff));
  lpmr_host host (.core_clk(core_clk), .cmd(cmd), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .derate_ff(derate_ff));
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Whole run needs under 160 cycles
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.mrr(a, d);
    check(d, exp);
  endtask : rd
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(8'(rl), 8'h03);
    check(8'(wl), 8'h01);
    check(8'(ds), 8'h02);
    check(8'(cal), 8'h01);
    rd(8'h04, 8'h03);
  endtask : t_reset
  task automatic t_latency;
    logic [3:0] rlx [0:7] = '{4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8};
    logic [2:0] wlx [0:7] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4};
    for (int c = 1; c < 8; c++)
    begin
      host.mrw(8'h02, 8'(c));
      @(posedge core_clk);
      #1;
      check(8'(rl), 8'(rlx[c]));
      check(8'(wl), 8'(wlx[c]));
    end
    rd(8'h02, 8'h00);
  endtask : t_latency
  task automatic t_drive;
    logic [3:0] dsx [0:8] = '{4'h2, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h7, 4'h7};
    for (int c = 0; c < 9; c++)
    begin
      host.mrw(8'h03, 8'(c));
      check(8'(ds), 8'(dsx[c]));
    end
    rd(8'h03, 8'h00);
    host.mrw(8'h0a, 8'hc3);
    check(8'(ds), 8'h02);
  endtask : t_drive
  task automatic t_cal;
    logic [7:0] code [0:3] = '{8'hff, 8'hab, 8'h56, 8'h12};
    logic [7:0] want [0:3] = '{8'h02, 8'h04, 8'h08, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      host.mrw(8'h0a, code[i]);
      check(8'(cal), want[i]);
    end
  endtask : t_cal
  task automatic t_ident;
    logic [7:0] ma [0:5] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0b};
    logic [7:0] val [0:5] = '{8'h5a, 8'h11, 8'h3c, 8'h0e, 8'h00, 8'h00};
    host.mrw(8'h05, 8'hff);
    for (int i = 0; i < 6; i++)
      rd(ma[i], val[i]);
  endtask : t_ident
  task automatic t_temp;
    logic [2:0] r [0:10] = '{3'h1, 3'h1, 3'h7, 3'h0, 3'h6, 3'h5, 3'h5, 3'h4, 3'h4, 3'h2, 3'h4};
    logic [7:0] t [0:10] = '{8'h14, 8'h14, 8'h6e, 8'h00, 8'h5a, 8'h32, 8'h5a, 8'h5a,
                             8'h14, 8'h14, 8'h14};
    logic [7:0] want [0:10] = '{8'h81, 8'h01, 8'h87, 8'h80, 8'h86, 8'h83, 8'h85, 8'h05,
                                8'h83, 8'h82, 8'h02};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge core_clk);
      #1 sensed_rate = r[i];
      sensed_temp_c = t[i];
      repeat (3) @(posedge core_clk);
      #1;
      check(8'(derate_ff), 8'(i == 4));
      rd(8'h04, want[i]);
    end
  endtask : t_temp
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1 resetn = 1'b1;
    t_reset();
    t_latency();
    t_drive();
    t_cal();
    t_ident();
    t_temp();
    tally_and_finish();
  end
endmodule : tb_top
